/* uec_copier.sv */
// APB-controlled copy engine between data RAM and USB endpoint buffers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "uec_params.svh"

module uec_copier
  import uec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_enable,
  input wire logic usb_int_enable,
  output logic usb_int,
  output logic cpu_stall,
  output uec_ram_req_s ram_req,
  input wire logic [7:0] ram_rdata,
  output uec_ep_req_s ep_req,
  input wire logic [7:0] ep_rdata
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] ep_size(input logic [2:0] eps);
    logic [7:0] sz;
    sz = `UEC_EP_SIZE_SMALL;
    if (eps == 3'h0) begin
      sz = `UEC_EP_SIZE_CTRL;
    end else if (eps < 3'h4) begin
      sz = `UEC_EP_SIZE_DUAL;
    end
    return sz;
  endfunction : ep_size

  function automatic logic launch_bad(input logic [2:0] eps, input logic [13:0] base,
                                      input logic [6:0] cnt);
    logic [14:0] last;
    logic bad;
    last = 15'({1'b0, base} + {8'h00, cnt} - 15'h0001);
    bad = 1'b0;
    // zero count or endpoint above four
    if (cnt == 7'h00 || eps > `UEC_EPS_MAX) begin
      bad = 1'b1;
    end
    if ({1'b0, base} < `UEC_WIN_LO || {1'b0, base} > `UEC_WIN_HI) begin
      bad = 1'b1;
    end
    if (last > `UEC_WIN_HI) begin
      bad = 1'b1;
    end
    if ({1'b0, cnt} > ep_size(eps)) begin
      bad = 1'b1;
    end
    return bad;
  endfunction : launch_bad

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  uec_state_s st;
  uec_state_s next_st;
  logic [7:0] reg_idx;
  logic hit;
  logic take;
  logic [7:0] rd_mux;
  logic [7:0] src_byte;

  assign reg_idx = paddr[9:2];
  assign hit = (paddr[1:0] == 2'h0) && (reg_idx == `UEC_IDX_CTL || reg_idx == `UEC_IDX_ADL ||
               reg_idx == `UEC_IDX_ADH || reg_idx == `UEC_IDX_CNT);
  assign take = psel && penable && st.pready;
  assign src_byte = st.dir ? ram_rdata : ep_rdata;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_idx)
      `UEC_IDX_CTL: rd_mux = {1'b0, st.eps, 1'b0, st.err, st.dir, st.run};
      `UEC_IDX_ADL: rd_mux = st.addr[7:0];
      `UEC_IDX_ADH: rd_mux = {2'h0, st.addr[13:8]};
      `UEC_IDX_CNT: rd_mux = {1'b0, st.cnt};
      default: rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.ram.re = 1'b0;
    next_st.ram.we = 1'b0;
    next_st.ep.re = 1'b0;
    next_st.ep.we = 1'b0;

    // Bus answers only while idle, so the core waits out a running copy
    if (psel && penable && !st.pready && st.fsm == UEC_IDLE) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !usb_enable || !hit;
      next_st.prdata = (usb_enable && hit && !pwrite) ? rd_mux : 8'h00;
    end

    if (take && pwrite && !st.pslverr) begin
      case (reg_idx)
        `UEC_IDX_CTL: begin
          next_st.eps = pwdata[`UEC_CTL_EPS_HI:`UEC_CTL_EPS_LO];
          next_st.dir = pwdata[`UEC_CTL_DIR];
          next_st.err = pwdata[`UEC_CTL_ERR];
          if (pwdata[`UEC_CTL_RUN]) begin
            // failed launch keeps address and count
            if (launch_bad(pwdata[`UEC_CTL_EPS_HI:`UEC_CTL_EPS_LO], st.addr, st.cnt)) begin
              next_st.err = 1'b1;
              next_st.run = 1'b0;
            end else begin
              next_st.err = 1'b0;
              next_st.run = 1'b1;
              next_st.stall = 1'b1;
              next_st.fsm = UEC_MOVE;
              next_st.idx = 8'h00;
              next_st.ep.sel = pwdata[`UEC_CTL_EPS_HI:`UEC_CTL_EPS_LO];
              next_st.ep.addr = 7'h00;
              next_st.ram.addr = st.addr;
              // receive reads the host-filled side of the buffer
              if (pwdata[`UEC_CTL_DIR]) begin
                next_st.ram.re = 1'b1;
              end else begin
                next_st.ep.re = 1'b1;
              end
            end
          end
        end
        `UEC_IDX_ADL: next_st.addr[7:0] = pwdata[7:0];
        `UEC_IDX_ADH: next_st.addr[13:8] = pwdata[5:0];
        `UEC_IDX_CNT: next_st.cnt = pwdata[6:0];
        default: next_st.cnt = st.cnt;
      endcase
    end

    if (st.fsm == UEC_MOVE) begin
      // one byte per cycle, N+1 cycles in all
      if (st.idx < {1'b0, st.cnt}) begin
        // ascending RAM addresses from the base
        if (st.dir) begin
          next_st.ep.we = 1'b1;
          next_st.ep.addr = st.idx[6:0];
          next_st.ep.wdata = src_byte;
        end else begin
          next_st.ram.we = 1'b1;
          next_st.ram.addr = 14'(st.addr + {6'h00, st.idx});
          next_st.ram.wdata = src_byte;
        end
        if (8'(st.idx + 8'h01) < {1'b0, st.cnt}) begin
          if (st.dir) begin
            next_st.ram.re = 1'b1;
            next_st.ram.addr = 14'(st.addr + {6'h00, st.idx} + 14'h0001);
          end else begin
            next_st.ep.re = 1'b1;
            next_st.ep.addr = 7'(st.idx + 8'h01);
          end
        end
        next_st.idx = 8'(st.idx + 8'h01);
      end else begin
        next_st.fsm = UEC_IDLE;
        // hardware clears run at the end
        next_st.run = 1'b0;
        next_st.stall = 1'b0;
        // address advances past the last byte
        next_st.addr = 14'(st.addr + {7'h00, st.cnt});
      end
    end

    // held back while a copy runs
    next_st.usb_int = next_st.err && usb_int_enable && next_st.fsm == UEC_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.addr <= {6'(`UEC_RST_ADH & `UEC_ADH_MASK), `UEC_RST_ADL};
      st.cnt <= 7'h00;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = {24'h000000, st.prdata};
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign usb_int = st.usb_int;
  assign cpu_stall = st.stall;
  assign ram_req = st.ram;
  assign ep_req = st.ep;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [7:0] stall_cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cyc <= 8'h00;
    end else begin
      stall_cyc <= cpu_stall ? 8'(stall_cyc + 8'h01) : 8'h00;
    end
  end

  a_stall_span: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_stall) |-> stall_cyc == 8'({1'b0, st.cnt} + 8'h01))
    else $error("copy stall length is not count plus one");

  a_bad_zero: assert property (@(posedge pclk) disable iff (!presetn)
    take && pwrite && !pslverr && reg_idx == `UEC_IDX_CTL && pwdata[0] && st.cnt == 7'h00
    |=> st.err && !cpu_stall && !st.run)
    else $error("zero count launch not flagged");

  a_bad_eps: assert property (@(posedge pclk) disable iff (!presetn)
    take && pwrite && !pslverr && reg_idx == `UEC_IDX_CTL && pwdata[0] && pwdata[6:4] > 3'h4
    |=> st.err && !cpu_stall)
    else $error("endpoint select above four not flagged");

  a_blocked_bus: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) && !$past(usb_enable) |-> pslverr && prdata == 32'h00000000)
    else $error("access while USB disabled not blocked");

  a_addr_after: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_stall) |-> st.addr == 14'($past(st.addr) + {7'h00, st.cnt})
    && st.cnt == $past(st.cnt) && !st.run)
    else $error("address or count wrong after copy");

  a_ram_ascend: assert property (@(posedge pclk) disable iff (!presetn)
    ram_req.we && $past(ram_req.we) |-> ram_req.addr == 14'($past(ram_req.addr) + 14'h0001))
    else $error("RAM writes not ascending");

  a_ram_window: assert property (@(posedge pclk) disable iff (!presetn)
    ram_req.re || ram_req.we |-> {1'b0, ram_req.addr} >= `UEC_WIN_LO
    && {1'b0, ram_req.addr} <= `UEC_WIN_HI)
    else $error("RAM access outside window");

  a_irq_held: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_stall |-> !usb_int)
    else $error("interrupt raised during a copy");

  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    st.err && usb_int_enable && !cpu_stall ##1 st.err && usb_int_enable |-> usb_int)
    else $error("error flag did not raise the interrupt");

endmodule : uec_copier
`default_nettype wire

/* uec_params.svh */
// Register indices, field positions, reset values and limits of the RAM/endpoint copier
//
// Contract
// - Registers are blocked (error answer, no effect) while the USB module is disabled.
// - A copy of N bytes finishes in N+1 cycles, one byte per cycle.
// - Launching a copy stalls the core; it resumes right after the copy ends.
// - A launch with zero bytes or endpoint select above four is a violation.
// - A clean launch clears the error flag in bit 2; software may clear it too.
// - A launch with base address outside the RAM window sets the error flag.
// - A launch whose base plus count runs past the window sets the error flag.
// - Count above the endpoint size (64, 2x64, 8 bytes) sets the error flag.
// - A set error flag raises the USB interrupt when USB interrupts are enabled.
// - Direction bit 1: zero copies endpoint to RAM, one copies RAM to endpoint.
// - Receive copies only return host data; written endpoint data is never read back.
// - Software launches with run bit 0; hardware clears it when the copy ends.
// - A copy cannot be interrupted; pending interrupts wait until it ends.
// - The top two bits of the high address register read as zero.
// - The address registers hold a 14-bit RAM base, source or destination.
// - Launch checks the window 0x0100..0x10FF; on error address and count stay.
// - After a copy the address holds the last RAM address used plus one.
// - The byte count register is seven bits and keeps its value after a copy.
`ifndef UEC_PARAMS_SVH
`define UEC_PARAMS_SVH

`define UEC_IDX_CTL 8'hEA
`define UEC_IDX_ADL 8'hEB
`define UEC_IDX_ADH 8'hEC
`define UEC_IDX_CNT 8'hED

`define UEC_RST_CTL 8'h00
`define UEC_RST_ADL 8'h00
`define UEC_RST_ADH 8'h01
`define UEC_RST_CNT 8'h00

`define UEC_CTL_RUN 0
`define UEC_CTL_DIR 1
`define UEC_CTL_ERR 2
`define UEC_CTL_EPS_LO 4
`define UEC_CTL_EPS_HI 6
`define UEC_ADH_MASK 8'h3F
`define UEC_CNT_MASK 8'h7F

`define UEC_EPS_MAX 3'h4
`define UEC_WIN_LO 15'h0100
`define UEC_WIN_HI 15'h10FF
`define UEC_EP_SIZE_CTRL 8'h40
`define UEC_EP_SIZE_DUAL 8'h80
`define UEC_EP_SIZE_SMALL 8'h08

`endif

/* uec_pkg.sv */
// Types shared by the RAM/endpoint copier
package uec_pkg;

  typedef enum logic [0:0] {
    UEC_IDLE = 1'b0,
    UEC_MOVE = 1'b1
  } uec_fsm_e;

  typedef struct packed {
    logic re;
    logic we;
    logic [13:0] addr;
    logic [7:0] wdata;
  } uec_ram_req_s;

  typedef struct packed {
    logic re;
    logic we;
    logic [2:0] sel;
    logic [6:0] addr;
    logic [7:0] wdata;
  } uec_ep_req_s;

  typedef struct packed {
    uec_fsm_e fsm;
    logic [2:0] eps;
    logic dir;
    logic err;
    logic run;
    logic [13:0] addr;
    logic [6:0] cnt;
    logic [7:0] idx;
    logic pready;
    logic pslverr;
    logic [7:0] prdata;
    logic stall;
    logic usb_int;
    uec_ram_req_s ram;
    uec_ep_req_s ep;
  } uec_state_s;

endpackage : uec_pkg

/* uec_mem_model.sv */
// Behavioural data RAM and endpoint buffers facing the copier
`timescale 1ns/10ps
`default_nettype none

module uec_mem_model
  import uec_pkg::*;
(
  input wire logic pclk,
  input wire uec_ram_req_s ram_req,
  output logic [7:0] ram_rdata,
  input wire uec_ep_req_s ep_req,
  output logic [7:0] ep_rdata
);
  logic [7:0] ram [0:16383];
  logic [7:0] ep [0:7][0:127];
  logic [7:0] last_ram = 8'h00;
  logic [7:0] last_ep = 8'h00;

  // Idle read lines show the inverse of the last byte
  assign ram_rdata = ram_req.re ? ram[ram_req.addr] : ~last_ram;
  assign ep_rdata = ep_req.re ? ep[ep_req.sel][ep_req.addr] : ~last_ep;

  always @(posedge pclk) begin
    if (ram_req.re) last_ram <= ram_rdata;
    if (ep_req.re) last_ep <= ep_rdata;
    if (ram_req.we) ram[ram_req.addr] <= ram_req.wdata;
    if (ep_req.we) ep[ep_req.sel][ep_req.addr] <= ep_req.wdata;
  end
endmodule : uec_mem_model
`default_nettype wire

/* usb_endpoint_ram_dma_tb.sv */
// Self-checking testbench of the RAM/endpoint copier
`timescale 1ns/10ps
`default_nettype none
`include "uec_params.svh"

module usb_endpoint_ram_dma_tb
  import uec_pkg::*;
;
  localparam logic [9:0] A_CTL = {`UEC_IDX_CTL, 2'b00};
  localparam logic [9:0] A_ADL = {`UEC_IDX_ADL, 2'b00};
  localparam logic [9:0] A_ADH = {`UEC_IDX_ADH, 2'b00};
  localparam logic [9:0] A_CNT = {`UEC_IDX_CNT, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic usb_enable = 1'b1;
  logic usb_int_enable = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, usb_int, cpu_stall;
  uec_ram_req_s ram_req;
  uec_ep_req_s ep_req;
  logic [7:0] ram_rdata, ep_rdata;
  logic [9:0] exp_q[$];
  logic [9:0] mon_e;
  logic [31:0] seed = 32'h19241D57;
  int errors = 0;
  int tests_run = 0;
  int stall_cnt = 0;
  int acc_cnt = 0;

  uec_copier dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_enable(usb_enable), .usb_int_enable(usb_int_enable),
    .usb_int(usb_int), .cpu_stall(cpu_stall), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .ep_req(ep_req), .ep_rdata(ep_rdata));
  uec_mem_model mem_u (.pclk(pclk), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .ep_req(ep_req), .ep_rdata(ep_rdata));

  initial begin
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // One APB transfer; e holds {check data, pslverr, data}
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                     input logic [9:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 600);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 600) begin
      errors++;
      wrap_up();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 10'h000);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h00, {2'b10, d});
  endtask : rd

  // Answer monitor with expectation queue, plus stall and access counters
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected answer", 8'h00, 8'hFF);
      end else begin
        mon_e = exp_q.pop_front();
        check("pslverr", {7'h0, mon_e[8]}, {7'h0, pslverr});
        if (mon_e[9]) check("prdata", mon_e[7:0], prdata[7:0]);
      end
    end
    if (cpu_stall === 1'b1) stall_cnt++;
    if (ram_req.re | ram_req.we | ep_req.re | ep_req.we) acc_cnt++;
  end

  task automatic copy(input logic [2:0] ep, input logic dir, input logic [13:0] base,
                      input logic [6:0] n, input logic bad);
    logic [13:0] fin;
    logic [7:0] cyc;
    fin = bad ? base : base + 14'(n);
    cyc = bad ? 8'h00 : 8'(n) + 8'h01;
    for (int k = 0; k < n; k++) begin
      mem_u.ram[14'(base + k)] = 8'(rnd());
      mem_u.ep[ep][k] = 8'(rnd());
    end
    wr(A_ADL, base[7:0]);
    wr(A_ADH, {2'b00, base[13:8]});
    wr(A_CNT, {1'b0, n});
    stall_cnt = 0;
    acc_cnt = 0;
    wr(A_CTL, {1'b0, ep, 2'b00, dir, 1'b1});
    rd(A_CTL, {1'b0, ep, 1'b0, bad, dir, 1'b0});
    rd(A_ADL, fin[7:0]);
    rd(A_ADH, {2'b00, fin[13:8]});
    rd(A_CNT, {1'b0, n});
    check("stall cycles", cyc, 8'(stall_cnt));
    check("access cycles", cyc, 8'(acc_cnt));
    for (int k = 0; k < n && !bad; k++) begin
      if (dir) check("ep byte", mem_u.ram[14'(base + k)], mem_u.ep[ep][k]);
      else check("ram byte", mem_u.ep[ep][k], mem_u.ram[14'(base + k)]);
    end
    check("usb_int", {7'h0, bad & usb_int_enable}, {7'h0, usb_int});
    wr(A_CTL, 8'h00);
    @(posedge pclk);
    check("usb_int cleared", 8'h00, {7'h0, usb_int});
    $display("test copy ep %0d dir %0d count %0d done", ep, dir, n);
  endtask : copy

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTL, 8'h00);
    rd(A_ADL, 8'h00);
    rd(A_ADH, 8'h01);
    rd(A_CNT, 8'h00);
    apb(1'b0, 10'h000, 8'h00, 10'h300);
    usb_enable <= 1'b0;
    apb(1'b1, A_ADL, 8'h5A, 10'h100);
    usb_enable <= 1'b1;
    rd(A_ADL, 8'h00);
    wr(A_ADH, 8'hFF);
    rd(A_ADH, 8'h3F);
    wr(A_CTL, 8'h88);
    rd(A_CTL, 8'h00);
    $display("test registers done");
    copy(3'h4, 1'b1, 14'h0100, 7'(1 + rnd() % 8), 1'b0);
    copy(3'h0, 1'b0, 14'h0100, 7'(1 + rnd() % 64), 1'b0);
    copy(3'h1, 1'b1, 14'h1000, 7'h7F, 1'b0);
    copy(3'h4, 1'b0, 14'h10F8, 7'h08, 1'b0);
    copy(3'h0, 1'b1, 14'h0100, 7'h00, 1'b1);
    copy(3'h5, 1'b1, 14'h0100, 7'h04, 1'b1);
    copy(3'h0, 1'b0, 14'h00FF, 7'h01, 1'b1);
    copy(3'h0, 1'b0, 14'h1100, 7'h01, 1'b1);
    copy(3'h4, 1'b1, 14'h10F9, 7'h08, 1'b1);
    copy(3'h0, 1'b1, 14'h0100, 7'h41, 1'b1);
    copy(3'h4, 1'b0, 14'h0100, 7'h09, 1'b1);
    usb_int_enable <= 1'b0;
    copy(3'h7, 1'b1, 14'h0100, 7'h02, 1'b1);
    wrap_up();
  end
endmodule : usb_endpoint_ram_dma_tb
`default_nettype wire
